/* File: inc/smrf_pkg.sv */
// Constants, types and decoding shared by both ends of the mode register link.
package smrf_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ            = 125;
  localparam int AUTO_INIT_MAX_NS   = 10000;
  // Longest time: round down.
  localparam int AUTO_INIT_CYCLES   = AUTO_INIT_MAX_NS * CLK_MHZ / 1000;
  localparam int CAL_INIT_NS        = 1000;
  // Least time: round up.
  localparam int CAL_INIT_CYCLES    = (CAL_INIT_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [7:0] IDX_DEVICE_STATUS_INFO     = 8'h00;
  localparam logic [7:0] IDX_FEATURE_CFG_A          = 8'h01;
  localparam logic [7:0] IDX_LATENCY_CFG            = 8'h02;
  localparam logic [7:0] IDX_IO_CFG                 = 8'h03;
  localparam logic [7:0] IDX_REFRESH_RATE_STATUS    = 8'h04;
  localparam logic [7:0] IDX_MAKER_CODE             = 8'h05;
  localparam logic [7:0] IDX_REVISION_CODE_A        = 8'h06;
  localparam logic [7:0] IDX_REVISION_CODE_B        = 8'h07;
  localparam logic [7:0] IDX_GEOMETRY_INFO          = 8'h08;
  localparam logic [7:0] IDX_TEST_MODE_CTL          = 8'h09;
  localparam logic [7:0] IDX_IO_CALIBRATION_CTL     = 8'h0A;
  localparam logic [7:0] IDX_BANK_SELF_REFRESH_MASK = 8'h10;
  localparam logic [7:0] IDX_RESERVED_WRITE_17      = 8'h11;
  localparam logic [7:0] IDX_DQ_PATTERN_A           = 8'h20;
  localparam logic [7:0] IDX_DQ_PATTERN_B           = 8'h28;
  localparam logic [7:0] IDX_SOFT_RESET_TRIGGER     = 8'h3F;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         AUTO_INIT_PENDING_POS  = 0;
  localparam int         MEMORY_TYPE_CODE_POS   = 1;
  localparam int         DATA_INVALID_POS       = 2;
  localparam int         CAL_RESULT_LSB         = 3;
  localparam logic       MEMORY_TYPE_CODE       = 1'b0;
  localparam logic       DATA_INVALID_SUPPORT   = 1'b0;
  localparam logic [1:0] CAL_NOT_RUN            = 2'h0;
  localparam logic [1:0] CAL_SUPPLY_OR_FLOAT    = 2'h1;
  localparam logic [1:0] CAL_SHORT_GROUND       = 2'h2;
  localparam logic [1:0] CAL_PASSED             = 2'h3;
  localparam logic [7:0] FEATURE_CFG_A_RST      = 8'h22;
  localparam logic [7:0] WO_REG_RST             = 8'h00;
  localparam logic [7:0] LOW_NIBBLE_MASK        = 8'h0F;
  localparam logic [7:0] FULL_MASK              = 8'hFF;
  localparam logic [7:0] CAL_INIT_OPCODE        = 8'hFF;

  // ****************************************************************
  // Controller registers on APB
  // ****************************************************************
  localparam logic [7:0] CMD_OFS         = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h0C;
  localparam int         CMD_OPERAND_LSB = 0;
  localparam int         CMD_INDEX_LSB   = 8;
  localparam int         CMD_WRITE_POS   = 16;
  localparam int         STATUS_BUSY_POS = 0;
  localparam int         STATUS_DATA_LSB = 8;
  localparam int         IRQ_READ_DONE   = 0;
  localparam int         IRQ_WRITE_DONE  = 1;
  localparam int         IRQ_REFUSED     = 2;
  localparam int         IRQ_CAL_FAULT   = 3;
  localparam int         IRQ_BITS        = 4;

  typedef enum logic [1:0] {ACC_RO, ACC_WO, ACC_RSVD_WO, ACC_RSVD}
    smrf_access_t;

  // Access class of a register index.
  function automatic smrf_access_t smrf_access(input logic [7:0] idx);
    case (idx)
      IDX_DEVICE_STATUS_INFO, IDX_REFRESH_RATE_STATUS, IDX_MAKER_CODE,
      IDX_REVISION_CODE_A, IDX_REVISION_CODE_B, IDX_GEOMETRY_INFO,
      IDX_DQ_PATTERN_A, IDX_DQ_PATTERN_B: smrf_access = ACC_RO;
      IDX_FEATURE_CFG_A, IDX_LATENCY_CFG, IDX_IO_CFG, IDX_TEST_MODE_CTL,
      IDX_IO_CALIBRATION_CTL, IDX_BANK_SELF_REFRESH_MASK,
      IDX_SOFT_RESET_TRIGGER: smrf_access = ACC_WO;
      IDX_RESERVED_WRITE_17: smrf_access = ACC_RSVD_WO;
      default: smrf_access = ACC_RSVD;
    endcase
  endfunction

  // Vendor-reserved index ranges.
  function automatic logic smrf_vendor(input logic [7:0] idx);
    smrf_vendor = (idx >= 8'h80 && idx <= 8'hBE) ||
                  (idx >= 8'hC0 && idx <= 8'hFE);
  endfunction

  // Operand bits that may be written as ones.
  function automatic logic [7:0] smrf_write_mask(input logic [7:0] idx);
    case (idx)
      IDX_LATENCY_CFG, IDX_IO_CFG: smrf_write_mask = LOW_NIBBLE_MASK;
      default: smrf_write_mask = FULL_MASK;
    endcase
  endfunction

endpackage

/* File: inc/smrf_if.sv */
// Mode register command link between controller and device.
interface smrf_if;
  logic       cmdValid;
  logic       cmdWrite;
  logic [7:0] cmdIndex;
  logic [7:0] cmdOperand;
  logic       rdValid;
  logic [7:0] rdData;
  logic       rdStrobe;

  modport device (
    input  cmdValid,
    input  cmdWrite,
    input  cmdIndex,
    input  cmdOperand,
    output rdValid,
    output rdData,
    output rdStrobe
  );

  modport controller (
    output cmdValid,
    output cmdWrite,
    output cmdIndex,
    output cmdOperand,
    input  rdValid,
    input  rdData,
    input  rdStrobe
  );
endinterface

/* File: verilog/smrf_device.sv */
// Device end: mode register file with auto-init and calibration self test.
//
// Implementation choice: the registers are reached only over the mode register link.
module smrf_device
  import smrf_pkg::*;
#(
  parameter int         INIT_CYCLES    = AUTO_INIT_CYCLES,
  parameter int         CAL_CYCLES     = CAL_INIT_CYCLES,
  parameter logic [2:0] REFRESH_RATE   = 3'h3,
  parameter logic       TEMP_UPDATE    = 1'b0,
  // Identification values are arbitrary.
  parameter logic [7:0] MAKER_ID       = 8'h5A,
  parameter logic [7:0] REVISION_A     = 8'h01,
  parameter logic [7:0] REVISION_B     = 8'h02,
  parameter logic [7:0] GEOMETRY       = 8'h00,
  parameter logic [7:0] PATTERN_A      = 8'h55,
  parameter logic [7:0] PATTERN_B      = 8'hAA
) (
  input  wire logic  mclk,
  input  wire logic  reset,
  smrf_if.device     link,
  input  wire logic  calPinToSupply,
  input  wire logic  calPinToGround,
  output logic       autoInitPending,
  output logic [1:0] calPinTestResult,
  output logic       factoryTrimActive,
  output logic [7:0] featureCfgA,
  output logic [7:0] latencyCfg,
  output logic [7:0] ioCfg,
  output logic [7:0] testModeCtl,
  output logic [7:0] ioCalibrationCtl,
  output logic [7:0] bankSelfRefreshMask
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : gInitBad
    $error("INIT_CYCLES out of range.");
  end
  if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : gCalBad
    $error("CAL_CYCLES out of range.");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    DEV_POWER_UP,
    DEV_AUTO_INIT,
    DEV_IDLE,
    DEV_CAL
  } smrf_dev_phase_t;

  typedef struct packed {
    logic            supMeta;
    logic            supSync;
    logic            gndMeta;
    logic            gndSync;
    smrf_dev_phase_t phase;
    logic [15:0]     count;
    logic [1:0]      calResult;
    logic [7:0]      featureCfgA;
    logic [7:0]      latencyCfg;
    logic [7:0]      ioCfg;
    logic [7:0]      testModeCtl;
    logic [7:0]      ioCalibrationCtl;
    logic [7:0]      bankMask;
    logic            rdValid;
    logic            rdStrobe;
    logic [7:0]      rdData;
  } smrf_dev_state_t;

  localparam smrf_dev_state_t DEV_RESET = '{
    phase       : DEV_POWER_UP,
    featureCfgA : FEATURE_CFG_A_RST,
    default     : '0
  };

  smrf_dev_state_t s;
  smrf_dev_state_t next_s;
  logic            trimLocked;

  assign trimLocked = (s.calResult == CAL_SUPPLY_OR_FLOAT) ||
                      (s.calResult == CAL_SHORT_GROUND);

  // Read answer for an index; undefined entries answer zero.
  function automatic logic [7:0] readValue(input logic [7:0] idx,
                                           input smrf_dev_state_t st);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_DEVICE_STATUS_INFO: begin
        v[AUTO_INIT_PENDING_POS] = (st.phase == DEV_POWER_UP) ||
                                   (st.phase == DEV_AUTO_INIT);
        v[MEMORY_TYPE_CODE_POS] = MEMORY_TYPE_CODE;
        v[DATA_INVALID_POS] = DATA_INVALID_SUPPORT;
        v[CAL_RESULT_LSB +: 2] = st.calResult;
      end
      IDX_REFRESH_RATE_STATUS: v = {TEMP_UPDATE, 4'h0, REFRESH_RATE};
      IDX_MAKER_CODE: v = MAKER_ID;
      IDX_REVISION_CODE_A: v = REVISION_A;
      IDX_REVISION_CODE_B: v = REVISION_B;
      IDX_GEOMETRY_INFO: v = GEOMETRY;
      IDX_DQ_PATTERN_A: v = PATTERN_A;
      IDX_DQ_PATTERN_B: v = PATTERN_B;
      default: v = 8'h00;
    endcase
    readValue = v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.supMeta = calPinToSupply;
    next_s.supSync = s.supMeta;
    next_s.gndMeta = calPinToGround;
    next_s.gndSync = s.gndMeta;
    next_s.rdValid = 1'b0;

    case (s.phase)
      DEV_POWER_UP: begin
        next_s.count = 16'h0000;
      end
      DEV_AUTO_INIT: begin
        if (s.count == 16'(INIT_CYCLES - 1)) begin
          next_s.phase = DEV_IDLE;
          next_s.count = 16'h0000;
        end else begin
          next_s.count = s.count + 16'h0001;
        end
      end
      DEV_CAL: begin
        if (s.count == 16'(CAL_CYCLES - 1)) begin
          next_s.phase = DEV_IDLE;
          next_s.count = 16'h0000;
          if (s.supSync) begin
            next_s.calResult = CAL_SUPPLY_OR_FLOAT;
          end else if (s.gndSync) begin
            next_s.calResult = CAL_SHORT_GROUND;
          end else begin
            next_s.calResult = CAL_PASSED;
          end
        end else begin
          next_s.count = s.count + 16'h0001;
        end
      end
      DEV_IDLE: begin
        next_s.count = 16'h0000;
      end
      default: begin
        next_s.phase = DEV_POWER_UP;
      end
    endcase

    if (link.cmdValid && !link.cmdWrite) begin
      next_s.rdValid = 1'b1;
      next_s.rdStrobe = ~s.rdStrobe;
      next_s.rdData = readValue(link.cmdIndex, s);
    end

    // Only write-only indices store; others are dropped.
    if (link.cmdValid && link.cmdWrite &&
        smrf_access(link.cmdIndex) == ACC_WO) begin
      case (link.cmdIndex)
        IDX_FEATURE_CFG_A: next_s.featureCfgA = link.cmdOperand;
        IDX_LATENCY_CFG: next_s.latencyCfg = link.cmdOperand;
        IDX_IO_CFG: next_s.ioCfg = link.cmdOperand;
        IDX_TEST_MODE_CTL: next_s.testModeCtl = link.cmdOperand;
        IDX_BANK_SELF_REFRESH_MASK: next_s.bankMask = link.cmdOperand;
        IDX_IO_CALIBRATION_CTL: begin
          next_s.ioCalibrationCtl = link.cmdOperand;
          if (link.cmdOperand == CAL_INIT_OPCODE &&
              s.phase == DEV_IDLE && !trimLocked) begin
            next_s.phase = DEV_CAL;
            next_s.count = 16'h0000;
          end
        end
        IDX_SOFT_RESET_TRIGGER: begin
          next_s.phase = DEV_AUTO_INIT;
          next_s.count = 16'h0000;
          next_s.calResult = CAL_NOT_RUN;
          next_s.featureCfgA = FEATURE_CFG_A_RST;
          next_s.latencyCfg = WO_REG_RST;
          next_s.ioCfg = WO_REG_RST;
          next_s.testModeCtl = WO_REG_RST;
          next_s.ioCalibrationCtl = WO_REG_RST;
          next_s.bankMask = WO_REG_RST;
        end
        default: begin
          next_s.phase = next_s.phase;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.rdValid = s.rdValid;
  assign link.rdData = s.rdData;
  assign link.rdStrobe = s.rdStrobe;
  assign autoInitPending = (s.phase == DEV_POWER_UP) ||
                           (s.phase == DEV_AUTO_INIT);
  assign calPinTestResult = s.calResult;
  assign factoryTrimActive = trimLocked;
  assign featureCfgA = s.featureCfgA;
  assign latencyCfg = s.latencyCfg;
  assign ioCfg = s.ioCfg;
  assign testModeCtl = s.testModeCtl;
  assign ioCalibrationCtl = s.ioCalibrationCtl;
  assign bankSelfRefreshMask = s.bankMask;

endmodule

/* File: verilog/smrf_controller.sv */
// Controller end: APB command registers that drive the mode register link.
module smrf_controller
  import smrf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  smrf_if.controller       link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    CTL_IDLE,
    CTL_ISSUE,
    CTL_WAIT_READ
  } smrf_ctl_phase_t;

  typedef struct packed {
    smrf_ctl_phase_t     phase;
    logic                cmdWrite;
    logic [7:0]          cmdIndex;
    logic [7:0]          cmdOperand;
    logic [7:0]          lastRead;
    logic [IRQ_BITS-1:0] irqStatus;
    logic [IRQ_BITS-1:0] irqMask;
    logic [31:0]         prdata;
  } smrf_ctl_state_t;

  localparam smrf_ctl_state_t CTL_RESET = '{
    phase   : CTL_IDLE,
    default : '0
  };

  smrf_ctl_state_t     s;
  smrf_ctl_state_t     next_s;
  logic                mapped;
  logic                accessWr;
  logic [IRQ_BITS-1:0] events;
  logic [7:0]          reqIndex;
  logic                reqWrite;
  logic                reqBad;

  assign mapped = (paddr == CMD_OFS) || (paddr == STATUS_OFS) ||
                  (paddr == IRQ_STATUS_OFS) || (paddr == IRQ_MASK_OFS);
  assign accessWr = psel && penable && pwrite;
  assign reqIndex = pwdata[CMD_INDEX_LSB +: 8];
  assign reqWrite = pwdata[CMD_WRITE_POS];
  assign reqBad = smrf_vendor(reqIndex) ||
                  (reqWrite && (smrf_access(reqIndex) == ACC_RSVD ||
                   smrf_access(reqIndex) == ACC_RSVD_WO));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    events = '0;

    case (s.phase)
      CTL_IDLE: begin
        next_s.phase = CTL_IDLE;
      end
      CTL_ISSUE: begin
        if (s.cmdWrite) begin
          next_s.phase = CTL_IDLE;
          events[IRQ_WRITE_DONE] = 1'b1;
        end else begin
          next_s.phase = CTL_WAIT_READ;
        end
      end
      CTL_WAIT_READ: begin
        if (link.rdValid) begin
          next_s.phase = CTL_IDLE;
          next_s.lastRead = link.rdData;
          events[IRQ_READ_DONE] = 1'b1;
          // Only 01 and 10 flag a fault; 11 just means a resistor is seen.
          if (s.cmdIndex == IDX_DEVICE_STATUS_INFO &&
              (link.rdData[CAL_RESULT_LSB +: 2] == CAL_SUPPLY_OR_FLOAT ||
               link.rdData[CAL_RESULT_LSB +: 2] == CAL_SHORT_GROUND)) begin
            events[IRQ_CAL_FAULT] = 1'b1;
          end
        end
      end
      default: begin
        next_s.phase = CTL_IDLE;
      end
    endcase

    if (accessWr && paddr == CMD_OFS) begin
      if (s.phase != CTL_IDLE || reqBad) begin
        events[IRQ_REFUSED] = 1'b1;
      end else begin
        next_s.phase = CTL_ISSUE;
        next_s.cmdWrite = reqWrite;
        next_s.cmdIndex = reqIndex;
        next_s.cmdOperand = pwdata[CMD_OPERAND_LSB +: 8] &
                            smrf_write_mask(reqIndex);
      end
    end
    if (accessWr && paddr == IRQ_MASK_OFS) begin
      next_s.irqMask = pwdata[IRQ_BITS-1:0];
    end
    // Write-one-to-clear; a new event in the same cycle wins.
    if (accessWr && paddr == IRQ_STATUS_OFS) begin
      next_s.irqStatus = s.irqStatus & ~pwdata[IRQ_BITS-1:0];
    end
    next_s.irqStatus = next_s.irqStatus | events;

    // Read data is prepared in the setup cycle.
    if (psel && !penable) begin
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        CMD_OFS: begin
          next_s.prdata[CMD_OPERAND_LSB +: 8] = s.cmdOperand;
          next_s.prdata[CMD_INDEX_LSB +: 8] = s.cmdIndex;
          next_s.prdata[CMD_WRITE_POS] = s.cmdWrite;
        end
        STATUS_OFS: begin
          next_s.prdata[STATUS_BUSY_POS] = (s.phase != CTL_IDLE);
          next_s.prdata[STATUS_DATA_LSB +: 8] = s.lastRead;
        end
        IRQ_STATUS_OFS: next_s.prdata[IRQ_BITS-1:0] = s.irqStatus;
        IRQ_MASK_OFS: next_s.prdata[IRQ_BITS-1:0] = s.irqMask;
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.cmdValid = (s.phase == CTL_ISSUE);
  assign link.cmdWrite = s.cmdWrite;
  assign link.cmdIndex = s.cmdIndex;
  assign link.cmdOperand = s.cmdOperand;
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(s.irqStatus & s.irqMask);

endmodule

/* File: tb/smrf_link_assertions.sv */
// Concurrent checks on the mode register link between the two ends.
module smrf_link_assertions (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       cmdValid,
  input wire logic       cmdWrite,
  input wire logic [7:0] cmdIndex,
  input wire logic [7:0] cmdOperand,
  input wire logic       rdValid,
  input wire logic [7:0] rdData,
  input wire logic       rdStrobe
);
  // ****************************************************************
  // Link properties
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_read_answer_due: assert property (
    cmdValid && !cmdWrite |=> rdValid)
    else $error("Read command got no answer.");
  a_answer_has_cause: assert property (
    rdValid |-> $past(cmdValid && !cmdWrite))
    else $error("Answer without a read command.");
  a_strobe_toggles: assert property (
    rdValid |-> rdStrobe != $past(rdStrobe))
    else $error("Strobe did not toggle on a read.");
  a_answer_holds: assert property (
    !rdValid |-> $stable(rdStrobe) && $stable(rdData))
    else $error("Read answer changed without a read.");
  a_status_rsvd_zero: assert property (
    rdValid && $past(cmdIndex) == 8'h00
    |-> rdData[7:5] == 3'h0 && rdData[2:1] == 2'h0)
    else $error("Status byte has set fixed bits.");
  a_wo_reads_zero: assert property (
    rdValid && $past(cmdIndex) inside {8'h01, 8'h02, 8'h03, 8'h09,
    8'h0A, 8'h10, 8'h3F} |-> rdData == 8'h00)
    else $error("Write-only read returned data.");
  a_refresh_rsvd_zero: assert property (
    rdValid && $past(cmdIndex) == 8'h04 |-> rdData[6:3] == 4'h0)
    else $error("Refresh byte has set spare bits.");
  a_no_vendor_cmd: assert property (
    cmdValid |-> !(cmdIndex inside {[8'h80:8'hBE], [8'hC0:8'hFE]}))
    else $error("Command sent to a vendor index.");
  a_no_rsvd_write: assert property (
    cmdValid && cmdWrite
    |-> cmdIndex != 8'h11 && !(cmdIndex inside {[8'h0B:8'h0F]}))
    else $error("Write sent to a reserved index.");
  a_write_rsvd_zero: assert property (
    cmdValid && cmdWrite && cmdIndex inside {8'h02, 8'h03}
    |-> cmdOperand[7:4] == 4'h0)
    else $error("Spare operand bits written as one.");
  c_status_read: cover property (rdValid && $past(cmdIndex) == 8'h00);
  c_cal_start: cover property (cmdValid && cmdWrite && cmdIndex == 8'h0A);
  c_soft_reset: cover property (cmdValid && cmdWrite && cmdIndex == 8'h3F);
endmodule

/* File: tb/sdram_mode_register_file_test.sv */
// Self-checking bench joining both ends of the mode register link.
module sdram_mode_register_file_test
  import smrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam int         INIT_N = 8;
  localparam int         CAL_N  = 4;
  // Identification value is arbitrary.
  localparam logic [7:0] MAKER  = 8'h3C;
  localparam logic [2:0] RATE   = 3'h5;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq;
  logic        calPinToSupply = 1'b0;
  logic        calPinToGround = 1'b0;
  logic        autoInitPending, factoryTrimActive;
  logic [1:0]  calPinTestResult;
  logic [7:0]  featureCfgA, latencyCfg, ioCfg, testModeCtl;
  logic [7:0]  ioCalibrationCtl, bankSelfRefreshMask;
  logic [7:0]  expWo [logic [7:0]];
  int          seed = 50243;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;

  smrf_if link ();
  smrf_device #(.INIT_CYCLES(INIT_N), .CAL_CYCLES(CAL_N),
    .REFRESH_RATE(RATE), .TEMP_UPDATE(1'b0), .MAKER_ID(MAKER))
  u_smrf_device (.mclk, .reset, .link, .calPinToSupply, .calPinToGround,
    .autoInitPending, .calPinTestResult, .factoryTrimActive, .featureCfgA,
    .latencyCfg, .ioCfg, .testModeCtl, .ioCalibrationCtl,
    .bankSelfRefreshMask);
  smrf_controller u_smrf_controller (.mclk, .reset, .link, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  smrf_link_assertions u_smrf_link_assertions (.mclk, .reset,
    .cmdValid(link.cmdValid), .cmdWrite(link.cmdWrite),
    .cmdIndex(link.cmdIndex), .cmdOperand(link.cmdOperand),
    .rdValid(link.rdValid), .rdData(link.rdData),
    .rdStrobe(link.rdStrobe));

  always #4 mclk = ~mclk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // The request stands until pready is seen high at a rising edge.
    do @(posedge mclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic wr, input logic [7:0] idx,
                     input logic [7:0] op, output logic [7:0] rd);
    logic [31:0] q;
    logic        e;
    apb(1'b1, CMD_OFS, {15'h0, wr, idx, op}, q, e);
    do apb(1'b0, STATUS_OFS, 32'h0, q, e);
    while (q[STATUS_BUSY_POS] !== 1'b0);
    rd = q[15:8];
  endtask

  task automatic model_reset();
    expWo[IDX_FEATURE_CFG_A] = FEATURE_CFG_A_RST;
    expWo[IDX_LATENCY_CFG] = WO_REG_RST;
    expWo[IDX_IO_CFG] = WO_REG_RST;
    expWo[IDX_TEST_MODE_CTL] = WO_REG_RST;
    expWo[IDX_IO_CALIBRATION_CTL] = WO_REG_RST;
    expWo[IDX_BANK_SELF_REFRESH_MASK] = WO_REG_RST;
  endtask

  task automatic mwrite(input logic [7:0] idx, input logic [7:0] op);
    logic [7:0] rd;
    cmd(1'b1, idx, op, rd);
    if (expWo.exists(idx))
      expWo[idx] = idx inside {IDX_LATENCY_CFG, IDX_IO_CFG} ?
                   op & LOW_NIBBLE_MASK : op;
    if (idx == IDX_SOFT_RESET_TRIGGER)
      model_reset();
  endtask

  task automatic mread(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    cmd(1'b0, idx, 8'h00, rd);
    check(rd, exp);
  endtask

  task automatic chk_cfg();
    @(negedge mclk);
    check(featureCfgA, expWo[IDX_FEATURE_CFG_A]);
    check(latencyCfg, expWo[IDX_LATENCY_CFG]);
    check(ioCfg, expWo[IDX_IO_CFG]);
    check(testModeCtl, expWo[IDX_TEST_MODE_CTL]);
    check(ioCalibrationCtl, expWo[IDX_IO_CALIBRATION_CTL]);
    check(bankSelfRefreshMask, expWo[IDX_BANK_SELF_REFRESH_MASK]);
  endtask

  initial begin
    static logic [7:0] bad [3] = '{8'h80, 8'hFE, IDX_RESERVED_WRITE_17};
    static logic [3:0] pins [3] = '{4'b1001, 4'b0110, 4'b0011};
    logic [31:0] q;
    logic        e;
    model_reset();
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check({7'h0, irq}, 8'h00);
    check({7'h0, autoInitPending}, 8'h01);
    chk_cfg();
    mread(IDX_DEVICE_STATUS_INFO, 8'h01);
    mwrite(IDX_SOFT_RESET_TRIGGER, 8'($random(seed)));
    repeat (INIT_N + 2) @(posedge mclk);
    @(negedge mclk);
    check({7'h0, autoInitPending}, 8'h00);
    mread(IDX_DEVICE_STATUS_INFO, 8'h00);
    foreach (expWo[i])
      if (i != IDX_IO_CALIBRATION_CTL)
        mwrite(i, 8'($random(seed)));
    chk_cfg();
    mread(IDX_LATENCY_CFG, 8'h00);
    mread(IDX_REFRESH_RATE_STATUS, {5'h0, RATE});
    mwrite(IDX_MAKER_CODE, ~MAKER);
    mread(IDX_MAKER_CODE, MAKER);
    chk_cfg();
    apb(1'b1, IRQ_MASK_OFS, 32'hF, q, e);
    foreach (bad[i]) begin
      apb(1'b1, IRQ_STATUS_OFS, 32'hF, q, e);
      mwrite(bad[i], 8'h00);
      apb(1'b0, IRQ_STATUS_OFS, 32'h0, q, e);
      check(q[7:0], 8'h04);
      @(negedge mclk);
      check({7'h0, irq}, 8'h01);
    end
    apb(1'b1, IRQ_MASK_OFS, 32'h0, q, e);
    @(negedge mclk);
    check({7'h0, irq}, 8'h00);
    apb(1'b1, IRQ_STATUS_OFS, 32'hF, q, e);
    apb(1'b0, IRQ_STATUS_OFS, 32'h0, q, e);
    check(q[7:0], 8'h00);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check({7'h0, e}, 8'h01);
    chk_cfg();
    foreach (pins[i]) begin
      @(posedge mclk);
      calPinToSupply <= pins[i][3];
      calPinToGround <= pins[i][2];
      mwrite(IDX_SOFT_RESET_TRIGGER, 8'h00);
      repeat (INIT_N + 2) @(posedge mclk);
      mread(IDX_DEVICE_STATUS_INFO, 8'h00);
      repeat (2) begin
        mwrite(IDX_IO_CALIBRATION_CTL, CAL_INIT_OPCODE);
        repeat (CAL_N + 2) @(posedge mclk);
        apb(1'b1, IRQ_STATUS_OFS, 32'hF, q, e);
        mread(IDX_DEVICE_STATUS_INFO, {3'h0, pins[i][1:0], 3'h0});
        apb(1'b0, IRQ_STATUS_OFS, 32'h0, q, e);
        check({7'h0, q[IRQ_CAL_FAULT]}, {7'h0, ^pins[i][1:0]});
        @(negedge mclk);
        check({6'h0, calPinTestResult}, {6'h0, pins[i][1:0]});
        check({7'h0, factoryTrimActive}, {7'h0, ^pins[i][1:0]});
        @(posedge mclk);
        calPinToSupply <= 1'b0;
        calPinToGround <= 1'b0;
      end
    end
    chk_cfg();
    print_verdict();
  end
endmodule
